// >>> hw/tmb_consts.svh
// Constants of the event, interrupt and sleep block of the 16-bit timer.
// Assumes inclusion by bare name from the package or design files.
`ifndef TMB_CONSTS_SVH
`define TMB_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define TMB_IDX_CONTROL_A 8'h00
`define TMB_IDX_CONTROL_B 8'h01
`define TMB_IDX_EVENT_CONTROL 8'h04
`define TMB_IDX_INT_ENABLE 8'h05
`define TMB_IDX_INT_FLAGS 8'h06
`define TMB_IDX_RUN_STATE 8'h07
`define TMB_IDX_DEBUG_HALT 8'h08
`define TMB_IDX_HIGH_LATCH 8'h09
`define TMB_IDX_COUNTER_LO 8'h0a
`define TMB_IDX_COUNTER_HI 8'h0b
`define TMB_IDX_COMPARE_LO 8'h0c
`define TMB_IDX_COMPARE_HI 8'h0d

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define TMB_CA_ENABLE 0
`define TMB_CA_CLKSRC_LSB 1
`define TMB_CA_SYNCUPD 4
`define TMB_CA_CASCADE 5
`define TMB_CA_STANDBY_RUN 6
`define TMB_CB_MODE_LSB 0
`define TMB_CB_OUT_EN 4
`define TMB_CB_OUT_INIT 5
`define TMB_CB_ASYNC 6
`define TMB_EC_CAPTURE_EVENT_EN 0
`define TMB_EC_EDGE 4
`define TMB_EC_FILTER 6
`define TMB_IRQ_CAPTURE_EVENT 0
`define TMB_IRQ_OVF 1
`define TMB_DBG_RUN 0

// ----------------------------------------------------------------------
// Writable masks and reset values
// ----------------------------------------------------------------------
`define TMB_MASK_CONTROL_A 8'h7f
`define TMB_MASK_CONTROL_B 8'h77
`define TMB_MASK_EVENT_CONTROL 8'h51
`define TMB_MASK_IRQ 8'h03
`define TMB_MASK_DEBUG 8'h01
`define TMB_RESET_BYTE 8'h00
`define TMB_RESET_WORD 16'h0000
`define TMB_COUNT_MAX 16'hffff
`endif

// >>> hw/tmb_pkg.sv
// Types of the event, interrupt and sleep block of the 16-bit timer.
// Assumes the constants header sits beside it.
`include "tmb_consts.svh"

package tmb_pkg;
  // Clock source select encodings
  typedef enum logic [2:0] {
    TMB_CLK_DIV1 = 3'h0,
    TMB_CLK_DIV2 = 3'h1,
    TMB_CLK_EVENT = 3'h7
  } tmb_clksrc_e;

  // Timer mode select encodings
  typedef enum logic [2:0] {
    TMB_MODE_PERIODIC = 3'h0,
    TMB_MODE_TIMEOUT = 3'h1,
    TMB_MODE_CAPTURE = 3'h2,
    TMB_MODE_FREQ = 3'h3,
    TMB_MODE_PULSE = 3'h4,
    TMB_MODE_FREQ_PULSE = 3'h5,
    TMB_MODE_SINGLE = 3'h6,
    TMB_MODE_PWM8 = 3'h7
  } tmb_mode_e;
endpackage

// >>> hw/tmb_timer_events.sv
// Event, interrupt and sleep core of a 16-bit timer with a Wishbone
// register file. Assumes a single 125 MHz clock; event and sleep
// inputs are synchronous to it.
//
// Operation
// - Event pulses mirror flag-setting conditions, one cycle
// - Capture and count event inputs act
// - Count input clocks counter only if selected
// - Capture enable gates edge and mode action
// - Async single-shot reacts to raw edges
// - Overflow on wrap from maximum to zero
// - Capture condition depends on the mode
// - Flags set whatever the enable bits
// - Separate enable bit per interrupt source
// - Request high while enabled flag set
// - Standby halts timer by default
// - Standby run bit keeps timer going
// - Power-down halts counting and events always
// - Clock source: divide one, two, event
// - Mode field selects capture, single, PWM
// - Edge bit picks active event edge
`timescale 1ns/100ps
`include "tmb_consts.svh"

module tmb_timer_events
  import tmb_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Event network
  input wire logic captureIn,
  input wire logic countIn,
  output logic captureEventOut,
  output logic overflowEventOut,
  // Sleep and debug state
  input wire logic sleepStandby,
  input wire logic sleepPowerDown,
  input wire logic debugHalt,
  // Interrupt request
  output logic irq
);

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  logic [7:0] controlA_ff;
  logic [7:0] controlB_ff;
  logic [7:0] eventControl_ff;
  logic [7:0] intEnable_ff;
  logic [7:0] interrupt_flag_bits_ff;
  logic [7:0] debugHalt_ff;
  logic [7:0] highLatch_ff;
  logic [15:0] counter_ff;
  logic [15:0] compare_ff;
  logic running_ff;
  logic div2_ff;
  logic captPrev_ff;
  logic countPrev_ff;
  logic captDelayed_ff;
  logic captDelPrev_ff;

  // Bus decode
  logic busReq;
  logic busWr;
  logic busRd;
  logic [7:0] regIdx;
  logic [7:0] wrByte;
  assign busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign busWr = busReq & wb_we_i & wb_sel_i[0];
  assign busRd = busReq & ~wb_we_i;
  assign regIdx = {2'b00, wb_adr_i};
  assign wrByte = wb_dat_i[7:0];

  // Field views
  logic enable;
  logic standbyRun;
  logic cascade;
  logic [2:0] clkSrc;
  tmb_mode_e mode;
  logic asyncMode;
  logic captEnable;
  logic edgeNeg;
  assign enable = controlA_ff[`TMB_CA_ENABLE];
  assign standbyRun = controlA_ff[`TMB_CA_STANDBY_RUN];
  assign cascade = controlA_ff[`TMB_CA_CASCADE];
  assign clkSrc = controlA_ff[`TMB_CA_CLKSRC_LSB +: 3];
  assign mode = tmb_mode_e'(controlB_ff[`TMB_CB_MODE_LSB +: 3]);
  assign asyncMode = controlB_ff[`TMB_CB_ASYNC];
  assign captEnable = eventControl_ff[`TMB_EC_CAPTURE_EVENT_EN];
  assign edgeNeg = eventControl_ff[`TMB_EC_EDGE];

  // ----------------------------------------------------------------------
  // Activity gating
  // ----------------------------------------------------------------------
  // Module alive while enabled unless a sleep or debug state stops it
  logic active;
  assign active = enable
    & ~sleepPowerDown
    & ~(sleepStandby & ~standbyRun)
    & ~(debugHalt & ~debugHalt_ff[`TMB_DBG_RUN]);

  // Edge detect on a pair of samples
  function automatic logic edgeOf(input logic cur, input logic prev, input logic neg);
    edgeOf = neg ? (prev & ~cur) : (cur & ~prev);
  endfunction

  // Counter tick per clock source
  logic tick;
  always_comb
  begin
    unique case (clkSrc)
      TMB_CLK_DIV1: tick = active;
      TMB_CLK_DIV2: tick = active & div2_ff;
      TMB_CLK_EVENT: tick = active & countIn & ~countPrev_ff;
      default: tick = 1'b0;
    endcase
  end

  // Capture source, delayed one clock when cascaded
  logic captSrc;
  logic captSrcPrev;
  assign captSrc = cascade ? captDelayed_ff : captureIn;
  assign captSrcPrev = cascade ? captDelPrev_ff : captPrev_ff;

  // Active and opposite capture edges, gated by the enable bit
  logic actEdge;
  logic oppEdge;
  assign actEdge = active & captEnable & edgeOf(captSrc, captSrcPrev, edgeNeg);
  assign oppEdge = active & captEnable & edgeOf(captSrc, captSrcPrev, ~edgeNeg);

  // ----------------------------------------------------------------------
  // Event sampling
  // ----------------------------------------------------------------------
  // Previous samples of both event inputs
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      captPrev_ff <= 1'b0;
      countPrev_ff <= 1'b0;
      captDelayed_ff <= 1'b0;
      captDelPrev_ff <= 1'b0;
    end
    else
    begin
      captPrev_ff <= captureIn;
      countPrev_ff <= countIn;
      captDelayed_ff <= captureIn;
      captDelPrev_ff <= captDelayed_ff;
    end
  end

  // Divide-by-two enable
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      div2_ff <= 1'b0;
    else if (active)
      div2_ff <= ~div2_ff;
  end

  // ----------------------------------------------------------------------
  // Counter, compare and conditions
  // ----------------------------------------------------------------------
  logic atTop;
  logic atMax;
  logic captCond;
  logic ovfCond;
  logic [15:0] nxt_counter;
  logic [15:0] nxt_compare;
  logic nxt_running;
  assign atMax = counter_ff == `TMB_COUNT_MAX;
  assign atTop = (mode == TMB_MODE_PWM8) ? (counter_ff[7:0] == compare_ff[7:0])
                                         : (counter_ff == compare_ff);

  // Mode action table
  always_comb
  begin
    nxt_counter = counter_ff;
    nxt_compare = compare_ff;
    nxt_running = running_ff;
    captCond = 1'b0;
    ovfCond = 1'b0;
    if (!enable)
      nxt_running = 1'b0;
    else if (tick & running_ff)
    begin
      nxt_counter = counter_ff + 16'h0001;
      ovfCond = atMax;
    end
    unique case (mode)
      TMB_MODE_PERIODIC, TMB_MODE_PWM8:
      begin
        if (enable)
          nxt_running = 1'b1;
        if (tick & atTop)
        begin
          nxt_counter = `TMB_RESET_WORD;
          captCond = 1'b1;
        end
      end
      TMB_MODE_TIMEOUT:
      begin
        if (actEdge)
        begin
          nxt_counter = `TMB_RESET_WORD;
          nxt_running = 1'b1;
        end
        else if (oppEdge)
          nxt_running = 1'b0;
        if (tick & running_ff & atTop)
          captCond = 1'b1;
      end
      TMB_MODE_CAPTURE:
      begin
        if (enable)
          nxt_running = 1'b1;
        if (actEdge)
        begin
          nxt_compare = counter_ff;
          captCond = 1'b1;
        end
      end
      TMB_MODE_FREQ:
      begin
        if (enable)
          nxt_running = 1'b1;
        if (actEdge)
        begin
          nxt_compare = counter_ff;
          nxt_counter = `TMB_RESET_WORD;
          captCond = 1'b1;
        end
      end
      TMB_MODE_PULSE, TMB_MODE_FREQ_PULSE:
      begin
        if (enable)
          nxt_running = 1'b1;
        if (actEdge)
          nxt_counter = `TMB_RESET_WORD;
        else if (oppEdge)
        begin
          nxt_compare = counter_ff;
          captCond = 1'b1;
        end
      end
      TMB_MODE_SINGLE:
      begin
        // Async form reacts to the unsynchronised edge at once
        if (asyncMode ? (captEnable & active
            & edgeOf(captureIn, captPrev_ff, edgeNeg)) : actEdge)
        begin
          nxt_counter = `TMB_RESET_WORD;
          nxt_running = 1'b1;
        end
        else if (tick & running_ff & atTop)
        begin
          nxt_running = 1'b0;
          captCond = 1'b1;
        end
      end
    endcase
    if (busWr & (regIdx == `TMB_IDX_COUNTER_HI))
      nxt_counter = {wrByte, highLatch_ff};
    if (busWr & (regIdx == `TMB_IDX_COMPARE_HI))
      nxt_compare = {wrByte, highLatch_ff};
  end

  // Counter, compare and running state
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      counter_ff <= `TMB_RESET_WORD;
      compare_ff <= `TMB_RESET_WORD;
      running_ff <= 1'b0;
    end
    else
    begin
      counter_ff <= nxt_counter;
      compare_ff <= nxt_compare;
      running_ff <= nxt_running;
    end
  end

  // ----------------------------------------------------------------------
  // Events and interrupts
  // ----------------------------------------------------------------------
  // Event pulses from the same conditions that set the flags
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      captureEventOut <= 1'b0;
      overflowEventOut <= 1'b0;
    end
    else
    begin
      captureEventOut <= captCond;
      overflowEventOut <= ovfCond;
    end
  end

  // Flags: set wins over write-one-to-clear
  logic [7:0] setMask;
  logic [7:0] clrMask;
  logic [7:0] nxt_flags;
  assign setMask = {6'h00, ovfCond, captCond};
  assign clrMask = (busWr & (regIdx == `TMB_IDX_INT_FLAGS)) ? (wrByte & `TMB_MASK_IRQ)
                                                           : 8'h00;
  assign nxt_flags = (interrupt_flag_bits_ff & ~clrMask) | setMask;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      interrupt_flag_bits_ff <= `TMB_RESET_BYTE;
    else
      interrupt_flag_bits_ff <= nxt_flags;
  end

  // Interrupt request while an enabled flag stands
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      irq <= 1'b0;
    else
      irq <= |(nxt_flags & intEnable_ff);
  end

  // ----------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------
  // Control, enable and debug registers
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      controlA_ff <= `TMB_RESET_BYTE;
      controlB_ff <= `TMB_RESET_BYTE;
      eventControl_ff <= `TMB_RESET_BYTE;
      intEnable_ff <= `TMB_RESET_BYTE;
      debugHalt_ff <= `TMB_RESET_BYTE;
    end
    else if (busWr)
    begin
      if (regIdx == `TMB_IDX_CONTROL_A)
        controlA_ff <= wrByte & `TMB_MASK_CONTROL_A;
      if (regIdx == `TMB_IDX_CONTROL_B)
        controlB_ff <= wrByte & `TMB_MASK_CONTROL_B;
      if (regIdx == `TMB_IDX_EVENT_CONTROL)
        eventControl_ff <= wrByte & `TMB_MASK_EVENT_CONTROL;
      if (regIdx == `TMB_IDX_INT_ENABLE)
        intEnable_ff <= wrByte & `TMB_MASK_IRQ;
      if (regIdx == `TMB_IDX_DEBUG_HALT)
        debugHalt_ff <= wrByte & `TMB_MASK_DEBUG;
    end
  end

  // High-byte latch: low writes park here, low reads fill it
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      highLatch_ff <= `TMB_RESET_BYTE;
    else if (busWr & ((regIdx == `TMB_IDX_HIGH_LATCH) | (regIdx == `TMB_IDX_COUNTER_LO)
             | (regIdx == `TMB_IDX_COMPARE_LO)))
      highLatch_ff <= wrByte;
    else if (busRd & (regIdx == `TMB_IDX_COUNTER_LO))
      highLatch_ff <= counter_ff[15:8];
    else if (busRd & (regIdx == `TMB_IDX_COMPARE_LO))
      highLatch_ff <= compare_ff[15:8];
  end

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------
  logic [7:0] rdByte;
  always_comb
  begin
    unique case (regIdx)
      `TMB_IDX_CONTROL_A: rdByte = controlA_ff;
      `TMB_IDX_CONTROL_B: rdByte = controlB_ff;
      `TMB_IDX_EVENT_CONTROL: rdByte = eventControl_ff;
      `TMB_IDX_INT_ENABLE: rdByte = intEnable_ff;
      `TMB_IDX_INT_FLAGS: rdByte = interrupt_flag_bits_ff;
      `TMB_IDX_RUN_STATE: rdByte = {7'h00, running_ff};
      `TMB_IDX_DEBUG_HALT: rdByte = debugHalt_ff;
      `TMB_IDX_HIGH_LATCH: rdByte = highLatch_ff;
      `TMB_IDX_COUNTER_LO: rdByte = counter_ff[7:0];
      `TMB_IDX_COUNTER_HI: rdByte = highLatch_ff;
      `TMB_IDX_COMPARE_LO: rdByte = compare_ff[7:0];
      `TMB_IDX_COMPARE_HI: rdByte = highLatch_ff;
      default: rdByte = 8'h00;
    endcase
  end

  // One-cycle acknowledge, read data registered with it
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end
    else
    begin
      wb_ack_o <= busReq;
      if (busRd)
        wb_dat_o <= {24'h000000, rdByte};
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_req;
    wb_cyc_i & wb_stb_i & ~wb_ack_o;
  endsequence

  sequence s_ackPulse;
    wb_ack_o ##1 ~wb_ack_o;
  endsequence

  property p_ack;
    @(posedge clock) disable iff (!reset_n)
      s_req |=> s_ackPulse;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle after request");

  property p_captEvent;
    @(posedge clock) disable iff (!reset_n)
      captCond |=> captureEventOut & interrupt_flag_bits_ff[`TMB_IRQ_CAPTURE_EVENT];
  endproperty
  a_captEvent: assert property (p_captEvent) else $error("capture event/flag mismatch");

  property p_ovfEvent;
    @(posedge clock) disable iff (!reset_n)
      overflowEventOut |-> interrupt_flag_bits_ff[`TMB_IRQ_OVF] & $past(atMax);
  endproperty
  a_ovfEvent: assert property (p_ovfEvent) else $error("overflow event without wrap");

  property p_wrap;
    @(posedge clock) disable iff (!reset_n)
      (tick & running_ff & atMax & mode == TMB_MODE_CAPTURE & ~actEdge & ~busWr)
      |=> counter_ff == `TMB_RESET_WORD ##0 overflowEventOut;
  endproperty
  a_wrap: assert property (p_wrap) else $error("counter did not wrap with overflow");

  property p_powerDown;
    @(posedge clock) disable iff (!reset_n)
      sleepPowerDown & ~busWr |=> $stable(counter_ff);
  endproperty
  a_powerDown: assert property (p_powerDown) else $error("counter moved in power-down");

  property p_standby;
    @(posedge clock) disable iff (!reset_n)
      sleepStandby & ~standbyRun & ~busWr |=> $stable(counter_ff);
  endproperty
  a_standby: assert property (p_standby) else $error("counter moved in standby");

  property p_irq;
    @(posedge clock) disable iff (!reset_n)
      ##1 irq == |($past(nxt_flags) & $past(intEnable_ff));
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt request mismatch");

  property p_flagHold;
    @(posedge clock) disable iff (!reset_n)
      interrupt_flag_bits_ff[`TMB_IRQ_CAPTURE_EVENT] & ~clrMask[`TMB_IRQ_CAPTURE_EVENT]
      |=> interrupt_flag_bits_ff[`TMB_IRQ_CAPTURE_EVENT];
  endproperty
  a_flagHold: assert property (p_flagHold) else $error("flag lost without clear");

  property p_capture;
    @(posedge clock) disable iff (!reset_n)
      actEdge & mode == TMB_MODE_CAPTURE & ~busWr |=> compare_ff == $past(counter_ff);
  endproperty
  a_capture: assert property (p_capture) else $error("capture value wrong");

  property p_noCaptDisabled;
    @(posedge clock) disable iff (!reset_n)
      ~captEnable & mode == TMB_MODE_CAPTURE |=> ~captureEventOut;
  endproperty
  a_noCaptDisabled: assert property (p_noCaptDisabled) else $error("capture while disabled");

endmodule

// >>> sim/tmb_event_net.sv
// Model of the event network facing the timer.
// Assumes the timer's clock and reset; changes events after rising edges.
`timescale 1ns/100ps

module tmb_event_net
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Events toward the timer
  output logic captureIn,
  output logic countIn,
  // Events from the timer
  input wire logic captureEventOut,
  input wire logic overflowEventOut
);
  int capCount = 0;
  int ovfCount = 0;

  // ----------------------------------------------------------------------
  // Event user side
  // ----------------------------------------------------------------------
  // Idle levels at start
  initial
  begin
    captureIn = 1'b0;
    countIn = 1'b0;
  end

  // Tally one-cycle event pulses
  always @(posedge clock)
  begin
    if (reset_n)
    begin
      capCount <= capCount + int'(captureEventOut);
      ovfCount <= ovfCount + int'(overflowEventOut);
    end
  end

  // ----------------------------------------------------------------------
  // Event generator side
  // ----------------------------------------------------------------------
  // New capture level, held two cycles so it is seen
  task automatic set_capture(input logic lvl);
    @(posedge clock);
    captureIn <= lvl;
    repeat (2) @(posedge clock);
  endtask

  // Count events, high one cycle then low three
  task automatic send_ticks(input int n);
    repeat (n)
    begin
      @(posedge clock);
      countIn <= 1'b1;
      @(posedge clock);
      countIn <= 1'b0;
      repeat (2) @(posedge clock);
    end
  endtask
endmodule

// >>> sim/tmb_timer_events_test.sv
// Self-checking bench of the timer event, interrupt and sleep core.
// Assumes the design package and constants header are compiled first.
`timescale 1ns/100ps
`include "tmb_consts.svh"

module tmb_timer_events_test
  import tmb_pkg::*;
;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [5:0] wbAdr = 6'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic wbAck;
  logic captureIn;
  logic countIn;
  logic capEvt;
  logic ovfEvt;
  logic sleepStandby = 1'b0;
  logic sleepPowerDown = 1'b0;
  logic debugHalt = 1'b0;
  logic irq;
  int fails = 0;
  int nCompared = 0;
  int cycles = 0;

  // ----------------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------------
  always #4 clock = ~clock;

  tmb_timer_events dut (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .captureIn(captureIn),
    .countIn(countIn), .captureEventOut(capEvt), .overflowEventOut(ovfEvt),
    .sleepStandby(sleepStandby), .sleepPowerDown(sleepPowerDown),
    .debugHalt(debugHalt), .irq(irq));

  tmb_event_net net (.clock(clock), .reset_n(reset_n), .captureIn(captureIn),
    .countIn(countIn), .captureEventOut(capEvt), .overflowEventOut(ovfEvt));

  // ----------------------------------------------------------------------
  // Compare, bus and report tasks
  // ----------------------------------------------------------------------
  task automatic checkv(input logic [15:0] got, input logic [15:0] exp);
    nCompared++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check1(input logic got, input logic exp);
    checkv({15'h0, got}, {15'h0, exp});
  endtask

  task automatic checkNum(input int got, input int exp);
    checkv(got[15:0], exp[15:0]);
  endtask

  // Classic cycle, held until ack is sampled high
  task automatic wb_access(input logic [7:0] idx, input logic we, input logic [7:0] wd,
      input logic [3:0] sel, output logic [7:0] rd);
    @(posedge clock);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= idx[5:0];
    wbSel <= sel;
    wbDatI <= {24'h0, wd};
    do
    begin
      @(posedge clock);
    end while (wbAck !== 1'b1);
    rd = wbDatO[7:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    check1(wbAck, 1'b1);
  endtask

  task automatic wb_write(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] rd;
    wb_access(idx, 1'b1, wd, 4'h1, rd);
  endtask

  task automatic read_check(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] rd;
    wb_access(idx, 1'b0, 8'h00, 4'h1, rd);
    checkv({8'h0, rd}, {8'h0, exp});
  endtask

  // Low byte first, so the high byte comes from the latch
  task automatic read16(input logic [7:0] idx, input logic [15:0] exp);
    logic [7:0] lo;
    logic [7:0] hi;
    wb_access(idx, 1'b0, 8'h00, 4'h1, lo);
    wb_access(idx + 8'h01, 1'b0, 8'h00, 4'h1, hi);
    checkv({hi, lo}, exp);
  endtask

  // Sleep and debug levels toward the design
  task automatic set_state(input logic sb, input logic pd, input logic dh);
    sleepStandby <= sb;
    sleepPowerDown <= pd;
    debugHalt <= dh;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic results();
    $display("compared %0d, mismatches %0d", nCompared, fails);
    if (fails == 0 && nCompared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Reset values, unmapped index, writable mask
  task automatic test_regs();
    logic [7:0] idxList [8] = '{`TMB_IDX_CONTROL_A, `TMB_IDX_CONTROL_B,
      `TMB_IDX_EVENT_CONTROL, `TMB_IDX_INT_ENABLE, `TMB_IDX_INT_FLAGS,
      `TMB_IDX_RUN_STATE, `TMB_IDX_DEBUG_HALT, `TMB_IDX_HIGH_LATCH};
    logic [7:0] rd;
    foreach (idxList[i])
      read_check(idxList[i], `TMB_RESET_BYTE);
    wb_access(`TMB_IDX_INT_ENABLE, 1'b1, 8'h03, 4'he, rd);
    read_check(`TMB_IDX_INT_ENABLE, 8'h00);
    wb_write(8'h02, 8'hff);
    read_check(8'h02, 8'h00);
    wb_write(`TMB_IDX_CONTROL_B, 8'hff);
    read_check(`TMB_IDX_CONTROL_B, `TMB_MASK_CONTROL_B);
    check1(irq, 1'b0);
    $display("register test done");
  endtask

  // Event clocking, wrap, flag without enable, write-one clear
  task automatic test_overflow();
    int o0;
    o0 = net.ovfCount;
    wb_write(`TMB_IDX_CONTROL_B, {5'h00, TMB_MODE_CAPTURE});
    wb_write(`TMB_IDX_COUNTER_LO, 8'hfd);
    wb_write(`TMB_IDX_COUNTER_HI, 8'hff);
    wb_write(`TMB_IDX_CONTROL_A, {4'h0, TMB_CLK_EVENT, 1'b1});
    net.send_ticks(2);
    read16(`TMB_IDX_COUNTER_LO, 16'hffff);
    checkNum(net.ovfCount - o0, 0);
    net.send_ticks(1);
    idle(2);
    checkNum(net.ovfCount - o0, 1);
    read_check(`TMB_IDX_INT_FLAGS, 8'h02);
    check1(irq, 1'b0);
    wb_write(`TMB_IDX_INT_ENABLE, 8'h02);
    idle(3);
    check1(irq, 1'b1);
    wb_write(`TMB_IDX_INT_FLAGS, 8'h00);
    idle(3);
    check1(irq, 1'b1);
    wb_write(`TMB_IDX_INT_FLAGS, 8'h02);
    idle(3);
    check1(irq, 1'b0);
    $display("overflow test done");
  endtask

  // Standby halts unless allowed; power-down always halts
  task automatic test_sleep();
    set_state(1'b1, 1'b0, 1'b0);
    net.send_ticks(2);
    read16(`TMB_IDX_COUNTER_LO, 16'h0000);
    wb_write(`TMB_IDX_CONTROL_A, {2'h1, 2'h0, TMB_CLK_EVENT, 1'b1});
    net.send_ticks(2);
    read16(`TMB_IDX_COUNTER_LO, 16'h0002);
    set_state(1'b1, 1'b1, 1'b0);
    net.send_ticks(2);
    read16(`TMB_IDX_COUNTER_LO, 16'h0002);
    set_state(1'b0, 1'b0, 1'b1);
    net.send_ticks(1);
    read16(`TMB_IDX_COUNTER_LO, 16'h0002);
    wb_write(`TMB_IDX_DEBUG_HALT, 8'h01);
    net.send_ticks(1);
    read16(`TMB_IDX_COUNTER_LO, 16'h0003);
    set_state(1'b0, 1'b0, 1'b0);
    net.send_ticks(1);
    read16(`TMB_IDX_COUNTER_LO, 16'h0004);
    $display("sleep test done");
  endtask

  // Capture on chosen edge only, gated by capture enable
  task automatic test_capture();
    int c0;
    c0 = net.capCount;
    wb_write(`TMB_IDX_EVENT_CONTROL, 8'h01);
    wb_write(`TMB_IDX_INT_ENABLE, 8'h01);
    net.set_capture(1'b1);
    idle(2);
    checkNum(net.capCount - c0, 1);
    read16(`TMB_IDX_COMPARE_LO, 16'h0004);
    read_check(`TMB_IDX_INT_FLAGS, 8'h01);
    check1(irq, 1'b1);
    net.set_capture(1'b0);
    idle(2);
    checkNum(net.capCount - c0, 1);
    wb_write(`TMB_IDX_INT_FLAGS, 8'h01);
    idle(3);
    check1(irq, 1'b0);
    wb_write(`TMB_IDX_EVENT_CONTROL, 8'h11);
    net.set_capture(1'b1);
    idle(2);
    checkNum(net.capCount - c0, 1);
    net.set_capture(1'b0);
    idle(2);
    checkNum(net.capCount - c0, 2);
    wb_write(`TMB_IDX_EVENT_CONTROL, 8'h10);
    net.set_capture(1'b1);
    net.set_capture(1'b0);
    idle(2);
    checkNum(net.capCount - c0, 2);
    $display("capture test done");
  endtask

  // Async single-shot: start on edge, stop and flag at compare
  task automatic test_single();
    int c0;
    c0 = net.capCount;
    wb_write(`TMB_IDX_INT_FLAGS, 8'h03);
    wb_write(`TMB_IDX_CONTROL_B, 8'h46);
    wb_write(`TMB_IDX_EVENT_CONTROL, 8'h01);
    net.set_capture(1'b1);
    read16(`TMB_IDX_COUNTER_LO, 16'h0000);
    net.send_ticks(4);
    read16(`TMB_IDX_COUNTER_LO, 16'h0004);
    read_check(`TMB_IDX_RUN_STATE, 8'h01);
    checkNum(net.capCount - c0, 0);
    net.send_ticks(1);
    checkNum(net.capCount - c0, 1);
    read_check(`TMB_IDX_RUN_STATE, 8'h00);
    read_check(`TMB_IDX_INT_FLAGS, 8'h01);
    $display("single-shot test done");
  endtask

  // ----------------------------------------------------------------------
  // Main sequence and hang guard
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge clock);
    reset_n <= 1'b1;
    test_regs();
    test_overflow();
    test_sleep();
    test_capture();
    test_single();
    results();
  end

  // Ceiling well above the few hundred cycles needed
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      results();
    end
  end
endmodule
